// >>> hw/lsc_link_ctrl.sv
// Per-link establishment and release state machine with APB registers.
// Assumes the frame receiver presents decoded unnumbered frames as
// one-cycle strobes and the transmitter accepts one send request per
// cycle; both sit on mclk.
//
// What this block does
// R1 - SABME: send UA, establish, indicate
// R2 - SABME establish clears counters, restarts T203
// R3 - SABME while awaiting release answers DM
// R4 - Establish command sends SABME, awaits establishment
// R5 - Track highest link number from SABME, establish, release
// R6 - UA while awaiting establishment: establish, confirm
// R7 - DM while awaiting establishment: stop T200, indicate
// R8 - Awaiting states ignore all but UA/DM/SABME/DISC
// R9 - T200 expiry resends, restarts, counts (lowest expired link only; dropped when a frame arrives that cycle)
// R10 - Count at N200: stop, release and error
// R11 - DISC: abort, UA, stop timers, state 4
// R12 - DISC while awaiting establishment answers DM
// R13 - Release command sends DISC, awaits release
// R14 - UA, or DM with final bit, awaiting release: state 4, confirm
// R15 - TEI removal moves link to unassigned
// R16 - Deactivate stops link, state code 0000
// R17 - Deactivate returns semaphore, clears active bit
// R18 - Host avoids removing connected links
// R19 - Same commands collide: send UA, wait
// R20 - Different commands collide: send DM
// R21 - DM with final bit ends pending command
// R22 - Queue start and relink commands
// R23 - TEI unassigned encoded as 1
// R24 - Semaphore FF when ready for command
// R25 - Per-link state, count, busy, variables
`timescale 1ns/1ns
`include "lsc_defs.svh"

module lsc_link_ctrl #(
  parameter int unsigned LINKS = 4,
  parameter int unsigned LW = 2,
  parameter int unsigned T200_CYC = `LSC_T200_CYC,
  parameter int unsigned T203_CYC = `LSC_T203_CYC
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic nrst,
  // APB.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Received unnumbered frames.
  input wire logic rx_valid,
  input wire logic [2:0] rx_frame,
  input wire logic rx_final,
  input wire logic [LW-1:0] rx_link,
  // Frames to send and aborts.
  output logic tx_valid,
  output logic [2:0] tx_frame,
  output logic [LW-1:0] tx_link,
  output logic abort_valid,
  output logic [LW-1:0] abort_link,
  // I frame queue linking.
  output logic queue_valid,
  output logic queue_relink,
  output logic [LW-1:0] queue_link,
  output logic [31:0] queue_head
);

  typedef struct packed {
    lsc_pkg::lsc_link_t [LINKS-1:0] link;
    lsc_pkg::lsc_seq_t seq;
    logic [3:0] cmd;
    logic [LW-1:0] cmd_link;
    logic [7:0] sem;
    logic [3:0] n200;
    logic [31:0] qhead;
    logic [LW-1:0] highest;
    logic [LW-1:0] sel;
    logic [4:0] events;
    logic [LW-1:0] ev_link;
    logic tx_valid;
    logic [2:0] tx_frame;
    logic [LW-1:0] tx_link;
    logic abort_valid;
    logic [LW-1:0] abort_link;
    logic queue_valid;
    logic queue_relink;
    logic [LW-1:0] queue_link;
    logic [31:0] queue_head;
  } lsc_ctrl_t;

  lsc_ctrl_t st_reg;
  lsc_ctrl_t st_next;

  logic wr_stb;
  logic rd_stb;
  logic [11:0] addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic decode_ok;
  logic [LINKS-1:0] t200_start;
  logic [LINKS-1:0] t200_stop;
  logic [LINKS-1:0] t200_exp;
  logic [LINKS-1:0] t203_start;
  logic [LINKS-1:0] t203_stop;

  ////////////////////////////////////////////////////////////////////////
  // Register bus.

  lsc_apb u_apb (
    .mclk(mclk),
    .nrst(nrst),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .wr_stb(wr_stb),
    .rd_stb(rd_stb),
    .addr(addr),
    .wdata(wdata),
    .rdata(rdata),
    .decode_ok(decode_ok)
  );

  function automatic logic is_reg(input logic [11:0] a);
    case (a)
      `LSC_OFF_CMD, `LSC_OFF_SEM, `LSC_OFF_CFG, `LSC_OFF_STATUS,
      `LSC_OFF_EVENT, `LSC_OFF_QUEUE, `LSC_OFF_HIGHEST,
      `LSC_OFF_SEL: is_reg = 1'b1;
      default: is_reg = 1'b0;
    endcase
  endfunction

  assign decode_ok = is_reg(addr);

  always_comb begin
    lsc_pkg::lsc_link_t s;
    s = st_reg.link[st_reg.sel];
    case (addr)
      `LSC_OFF_CMD: rdata = {20'h00000, 4'h0, 2'(st_reg.cmd_link),
                             2'h0, st_reg.cmd};
      `LSC_OFF_SEM: rdata = {24'h000000, st_reg.sem};
      `LSC_OFF_CFG: rdata = {28'h0000000, st_reg.n200};
      `LSC_OFF_STATUS: rdata = {1'h0, s.active, s.peer_busy, s.va,
                                s.vr, s.vs, s.retx, s.state};
      `LSC_OFF_EVENT: rdata = {22'h000000, 2'(st_reg.ev_link),
                               3'h0, st_reg.events};
      `LSC_OFF_QUEUE: rdata = st_reg.qhead;
      `LSC_OFF_HIGHEST: rdata = {30'h00000000, 2'(st_reg.highest)};
      `LSC_OFF_SEL: rdata = {30'h00000000, 2'(st_reg.sel)};
      default: rdata = 32'h0000_0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Timers, one pair per link.

  genvar g;
  generate
    for (g = 0; g < LINKS; g++) begin : g_tmr
      lsc_timer u_t200 (
        .mclk(mclk),
        .nrst(nrst),
        .start(t200_start[g]),
        .stop(t200_stop[g]),
        .period(T200_CYC),
        .expired(t200_exp[g])
      );
      lsc_timer u_t203 (
        .mclk(mclk),
        .nrst(nrst),
        .start(t203_start[g]),
        .stop(t203_stop[g]),
        .period(T203_CYC),
        .expired()
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Link state machine.

  function automatic lsc_pkg::lsc_link_t clr_vars(
      input lsc_pkg::lsc_link_t l);
    lsc_pkg::lsc_link_t r;
    r = l;
    r.peer_busy = 1'b0;
    r.vs = 7'h00;
    r.vr = 7'h00;
    r.va = 7'h00;
    return r;
  endfunction

  always_comb begin
    lsc_pkg::lsc_link_t l;
    logic [LW-1:0] k;
    logic frame_done;
    l = '0;
    k = '0;
    frame_done = 1'b0;
    st_next = st_reg;
    st_next.tx_valid = 1'b0;
    st_next.abort_valid = 1'b0;
    st_next.queue_valid = 1'b0;
    t200_start = '0;
    t200_stop = '0;
    t203_start = '0;
    t203_stop = '0;

    // Received frames take priority; a command waits one cycle.
    if (rx_valid) begin
      k = rx_link;
      l = st_reg.link[k];
      frame_done = 1'b1;
      case (rx_frame)
        `LSC_FR_SABME: begin
          if (l.state == `LSC_ST_AWAITING_RELEASE_STATE) begin
            // R3 - Refuse with DM
            // R20 - Different collision DM
            st_next.tx_frame = `LSC_FR_DM;
          end else if (l.state == `LSC_ST_AWAITING_ESTABLISHMENT_STATE) begin
            // R19 - Same collision UA
            st_next.tx_frame = `LSC_FR_UA;
          end else begin
            // R1 - Accept with UA
            st_next.tx_frame = `LSC_FR_UA;
            // R2 - Clear and restart T203
            l = clr_vars(l);
            l.retx = 4'h0;
            l.state = `LSC_ST_EST_NORMAL;
            l.t203_run = 1'b1;
            t203_start[k] = 1'b1;
            st_next.events = 5'h01 << `LSC_EV_EST_IND;
            st_next.ev_link = k;
            // R5 - Highest link
            if (k > st_reg.highest) st_next.highest = k;
          end
          st_next.tx_valid = 1'b1;
          st_next.tx_link = k;
        end
        `LSC_FR_DISC: begin
          st_next.tx_valid = 1'b1;
          st_next.tx_link = k;
          if (l.state == `LSC_ST_AWAITING_ESTABLISHMENT_STATE) begin
            // R12 - DM, state kept
            // R20 - Different collision DM
            st_next.tx_frame = `LSC_FR_DM;
          end else if (l.state == `LSC_ST_AWAITING_RELEASE_STATE) begin
            // R19 - Same collision UA
            st_next.tx_frame = `LSC_FR_UA;
          end else begin
            // R11 - Abort, UA, release
            st_next.tx_frame = `LSC_FR_UA;
            st_next.abort_valid = 1'b1;
            st_next.abort_link = k;
            t200_stop[k] = 1'b1;
            t203_stop[k] = 1'b1;
            l.t200_run = 1'b0;
            l.t203_run = 1'b0;
            l.state = `LSC_ST_STATE_A;
            st_next.events = 5'h01 << `LSC_EV_REL_IND;
            st_next.ev_link = k;
          end
        end
        `LSC_FR_UA, `LSC_FR_DM: begin
          if (l.state == `LSC_ST_AWAITING_ESTABLISHMENT_STATE) begin
            t200_stop[k] = 1'b1;
            l.t200_run = 1'b0;
            st_next.ev_link = k;
            if (rx_frame == `LSC_FR_UA) begin
              // R6 - Confirm establishment
              l = clr_vars(l);
              l.state = `LSC_ST_EST_NORMAL;
              st_next.events = 5'h01 << `LSC_EV_EST_CONF;
            end else begin
              // R7 - Stop T200, indicate
              // R21 - DM after SABME
              l.state = `LSC_ST_STATE_A;
              st_next.events = 5'h01 << `LSC_EV_REL_IND;
            end
          end else if (l.state == `LSC_ST_AWAITING_RELEASE_STATE &&
                       (rx_frame == `LSC_FR_UA || rx_final)) begin
            // R14 - Confirm release
            // R21 - DM after DISC
            t200_stop[k] = 1'b1;
            l.t200_run = 1'b0;
            l.state = `LSC_ST_STATE_A;
            st_next.events = 5'h01 << `LSC_EV_REL_CONF;
            st_next.ev_link = k;
          end
        end
        // R8 - Others ignored
        default: frame_done = 1'b1;
      endcase
      st_next.link[k] = l;
    end else if (|t200_exp) begin
      for (int i = 0; i < LINKS; i++) begin
        if (t200_exp[i] && !frame_done) begin
          frame_done = 1'b1;
          k = LW'(i);
          l = st_reg.link[k];
          if (l.state == `LSC_ST_AWAITING_ESTABLISHMENT_STATE ||
              l.state == `LSC_ST_AWAITING_RELEASE_STATE) begin
            if (l.retx + 4'h1 >= st_reg.n200) begin
              // R10 - Give up
              l.t200_run = 1'b0;
              l.retx = st_reg.n200;
              l.state = `LSC_ST_STATE_A;
              st_next.events = (5'h01 << `LSC_EV_REL_IND) |
                               (5'h01 << `LSC_EV_MGMT_ERR);
              st_next.ev_link = k;
            end else begin
              // R9 - Resend and count
              l.retx = l.retx + 4'h1;
              t200_start[k] = 1'b1;
              st_next.tx_valid = 1'b1;
              st_next.tx_link = k;
              st_next.tx_frame = (l.state == `LSC_ST_AWAITING_ESTABLISHMENT_STATE) ?
                                 `LSC_FR_SABME : `LSC_FR_DISC;
            end
          end
          st_next.link[k] = l;
        end
      end
    end else begin
      case (st_reg.seq)
        lsc_pkg::LSC_EXEC: begin
          k = st_reg.cmd_link;
          l = st_reg.link[k];
          st_next.seq = lsc_pkg::LSC_DONE;
          case (st_reg.cmd)
            `LSC_CMD_ESTABLISH, `LSC_CMD_RELEASE: begin
              // R4 - Send SABME
              // R13 - Send DISC
              st_next.tx_valid = 1'b1;
              st_next.tx_link = k;
              st_next.tx_frame = (st_reg.cmd == `LSC_CMD_ESTABLISH) ?
                                 `LSC_FR_SABME : `LSC_FR_DISC;
              t200_start[k] = 1'b1;
              l.t200_run = 1'b1;
              l.retx = 4'h0;
              l.active = 1'b1;
              l.state = (st_reg.cmd == `LSC_CMD_ESTABLISH) ?
                        `LSC_ST_AWAITING_ESTABLISHMENT_STATE : `LSC_ST_AWAITING_RELEASE_STATE;
              // R5 - Highest link
              if (k > st_reg.highest) st_next.highest = k;
            end
            `LSC_CMD_TEI_ASSIGN: begin
              l.active = 1'b1;
              if (l.state == `LSC_ST_TEI_UNASSIGNED ||
                  l.state == `LSC_ST_UNINIT) begin
                l.state = `LSC_ST_STATE_A;
              end
            end
            // R15 - Remove TEI
            // R23 - Unassigned code 1
            `LSC_CMD_TEI_REMOVE: l.state = `LSC_ST_TEI_UNASSIGNED;
            `LSC_CMD_DEACTIVATE: begin
              // R16 - Uninitialized state
              // R17 - Clear active bit
              t200_stop[k] = 1'b1;
              t203_stop[k] = 1'b1;
              st_next.abort_valid = 1'b1;
              st_next.abort_link = k;
              l = '0;
            end
            `LSC_CMD_QUEUE_START, `LSC_CMD_QUEUE_RELINK: begin
              // R22 - Link I queue
              st_next.queue_valid = 1'b1;
              st_next.queue_relink = (st_reg.cmd == `LSC_CMD_QUEUE_RELINK);
              st_next.queue_link = k;
              st_next.queue_head = st_reg.qhead;
            end
            default: st_next.seq = lsc_pkg::LSC_DONE;
          endcase
          st_next.link[k] = l;
        end
        lsc_pkg::LSC_DONE: begin
          // R24 - Ready again
          // R17 - Semaphore back
          st_next.sem = `LSC_SEM_READY;
          st_next.seq = lsc_pkg::LSC_IDLE;
        end
        default: st_next.seq = lsc_pkg::LSC_IDLE;
      endcase
    end

    // R25 - Per-link context
    if (wr_stb) begin
      case (addr)
        `LSC_OFF_CMD: begin
          if (st_reg.sem == `LSC_SEM_READY) begin
            st_next.cmd = wdata[3:0];
            st_next.cmd_link = wdata[8 +: LW];
            st_next.sem = `LSC_SEM_BUSY;
            st_next.seq = lsc_pkg::LSC_EXEC;
          end
        end
        `LSC_OFF_CFG: st_next.n200 = wdata[3:0];
        `LSC_OFF_QUEUE: st_next.qhead = wdata;
        `LSC_OFF_SEL: st_next.sel = wdata[LW-1:0];
        default: st_next.qhead = st_next.qhead;
      endcase
    end
    // Hardware-set event bits win over the read-to-clear, unless they equal the bits already held.
    if (rd_stb && addr == `LSC_OFF_EVENT &&
        st_next.events == st_reg.events) begin
      st_next.events = 5'h00;
    end else if (st_next.events != st_reg.events) begin
      st_next.events = st_next.events | st_reg.events;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      st_reg <= '0;
      st_reg.sem <= `LSC_SEM_READY;
      st_reg.n200 <= `LSC_N200_DEFAULT;
    end else begin
      st_reg <= st_next;
    end
  end

  assign tx_valid = st_reg.tx_valid;
  assign tx_frame = st_reg.tx_frame;
  assign tx_link = st_reg.tx_link;
  assign abort_valid = st_reg.abort_valid;
  assign abort_link = st_reg.abort_link;
  assign queue_valid = st_reg.queue_valid;
  assign queue_relink = st_reg.queue_relink;
  assign queue_link = st_reg.queue_link;
  assign queue_head = st_reg.queue_head;

endmodule

// >>> hw/lsc_defs.svh
// Constants for the link state control block.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef LSC_DEFS_SVH
`define LSC_DEFS_SVH

// Link state codes.
`define LSC_ST_UNINIT 4'h0
`define LSC_ST_TEI_UNASSIGNED 4'h1
`define LSC_ST_STATE_A 4'h4
`define LSC_ST_AWAITING_ESTABLISHMENT_STATE 4'h5
`define LSC_ST_AWAITING_RELEASE_STATE 4'h6
`define LSC_ST_EST_NORMAL 4'h7

// Frame codes.
`define LSC_FR_NONE 3'h0
`define LSC_FR_SABME 3'h1
`define LSC_FR_UA 3'h2
`define LSC_FR_DM 3'h3
`define LSC_FR_DISC 3'h4
`define LSC_FR_OTHER 3'h5

// Host command codes.
`define LSC_CMD_ESTABLISH 4'h1
`define LSC_CMD_RELEASE 4'h2
`define LSC_CMD_TEI_REMOVE 4'h3
`define LSC_CMD_DEACTIVATE 4'h4
`define LSC_CMD_QUEUE_START 4'h5
`define LSC_CMD_QUEUE_RELINK 4'h6
`define LSC_CMD_TEI_ASSIGN 4'h7

// Semaphore values.
`define LSC_SEM_READY 8'hff
`define LSC_SEM_BUSY 8'h00

// Register byte offsets.
`define LSC_OFF_CMD 12'h000
`define LSC_OFF_SEM 12'h004
`define LSC_OFF_CFG 12'h008
`define LSC_OFF_STATUS 12'h00c
`define LSC_OFF_EVENT 12'h010
`define LSC_OFF_QUEUE 12'h014
`define LSC_OFF_HIGHEST 12'h018
`define LSC_OFF_SEL 12'h01c

// Timer defaults.
`define LSC_CLK_MHZ 25
`define LSC_T200_US 1000000
`define LSC_T203_US 10000000
`define LSC_T200_CYC (`LSC_T200_US * `LSC_CLK_MHZ)
`define LSC_T203_CYC (`LSC_T203_US * `LSC_CLK_MHZ)
`define LSC_N200_DEFAULT 4'h3

// Event bit positions.
`define LSC_EV_EST_IND 0
`define LSC_EV_EST_CONF 1
`define LSC_EV_REL_IND 2
`define LSC_EV_REL_CONF 3
`define LSC_EV_MGMT_ERR 4

`endif

// >>> hw/lsc_pkg.sv
// Types shared by the link state control modules.
// Assumes lsc_defs.svh is on the include path.
`include "lsc_defs.svh"

package lsc_pkg;

  typedef enum logic [1:0] {
    LSC_IDLE = 2'b00,
    LSC_EXEC = 2'b01,
    LSC_DONE = 2'b10
  } lsc_seq_t;

  typedef struct packed {
    logic [3:0] state;
    logic [3:0] retx;
    logic peer_busy;
    logic [6:0] vs;
    logic [6:0] vr;
    logic [6:0] va;
    logic active;
    logic t200_run;
    logic t203_run;
    logic [2:0] pend;
  } lsc_link_t;

endpackage

// >>> hw/lsc_timer.sv
// Per-link down counter for T200 or T203.
// Assumes start and stop come from logic on mclk.
`timescale 1ns/1ns
`include "lsc_defs.svh"

module lsc_timer #(
  parameter int unsigned CNT_W = 32
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic nrst,
  // Control.
  input wire logic start,
  input wire logic stop,
  input wire logic [CNT_W-1:0] period,
  // Status.
  output logic expired
);

  typedef struct packed {
    logic [CNT_W-1:0] count;
    logic running;
    logic expired;
  } lsc_timer_t;

  lsc_timer_t st_reg;
  lsc_timer_t st_next;

  always_comb begin
    st_next = st_reg;
    st_next.expired = 1'b0;
    if (start) begin
      st_next.count = period;
      st_next.running = 1'b1;
    end else if (stop) begin
      st_next.running = 1'b0;
    end else if (st_reg.running) begin
      if (st_reg.count <= CNT_W'(1)) begin
        st_next.running = 1'b0;
        st_next.expired = 1'b1;
      end else begin
        st_next.count = st_reg.count - CNT_W'(1);
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign expired = st_reg.expired;

endmodule

// >>> hw/lsc_apb.sv
// APB slave front end with no wait states.
// Assumes an APB master on mclk.
`timescale 1ns/1ns

module lsc_apb (
  // Clock and reset.
  input wire logic mclk,
  input wire logic nrst,
  // APB.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Register side.
  output logic wr_stb,
  output logic rd_stb,
  output logic [11:0] addr,
  output logic [31:0] wdata,
  input wire logic [31:0] rdata,
  input wire logic decode_ok
);

  typedef struct packed {
    logic [31:0] prdata;
  } lsc_apb_t;

  lsc_apb_t st_reg;
  lsc_apb_t st_next;

  always_comb begin
    st_next = st_reg;
    if (psel && !penable && !pwrite) begin
      st_next.prdata = decode_ok ? rdata : 32'h0000_0000;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Read data is captured in setup so the access phase needs no wait.
  assign prdata = st_reg.prdata;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !decode_ok;
  assign wr_stb = psel && penable && pwrite && decode_ok;
  assign rd_stb = psel && penable && !pwrite && decode_ok;
  assign addr = paddr;
  assign wdata = pwdata;

endmodule

// >>> bench/lsc_link_ctrl_monitor.sv
// Checker for the link state control block, bound to its top module.
// Assumes it sees only that module's ports, all on mclk.
`timescale 1ns/1ns

module lsc_link_ctrl_monitor #(
  parameter int unsigned LW = 2
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic nrst,
  // APB.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Frames.
  input wire logic rx_valid,
  input wire logic [2:0] rx_frame,
  input wire logic rx_final,
  input wire logic [LW-1:0] rx_link,
  input wire logic tx_valid,
  input wire logic [2:0] tx_frame,
  input wire logic [LW-1:0] tx_link,
  input wire logic abort_valid,
  input wire logic [LW-1:0] abort_link,
  // Queue linking.
  input wire logic queue_valid,
  input wire logic queue_relink,
  input wire logic [LW-1:0] queue_link,
  input wire logic [31:0] queue_head
);
  // Any write to the command offset counts, whether or not the semaphore was ready.
  wire cmd_wr = psel && penable && pwrite && paddr == 12'h000;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);

  //////////////////////////////////////////////////////////////////////////
  chk_sabme_reply: assert property (
    rx_valid && rx_frame == 3'h1 |=> tx_valid && tx_link == $past(rx_link)
      && tx_frame inside {3'h2, 3'h3})
    else $error("received SABME not answered next cycle");
  chk_disc_reply: assert property (
    rx_valid && rx_frame == 3'h4 |=> tx_valid && tx_link == $past(rx_link)
      && tx_frame inside {3'h2, 3'h3})
    else $error("received DISC not answered next cycle");
  chk_resp_silent: assert property (
    rx_valid && rx_frame inside {3'h2, 3'h3, 3'h5}
      |=> !(tx_valid && tx_frame inside {3'h2, 3'h3}))
    else $error("response frame was answered");
  chk_est_cmd: assert property (
    cmd_wr && pwdata[3:0] == 4'h1 |-> ##[1:8] tx_valid && tx_frame == 3'h1)
    else $error("establish command sent no SABME");
  chk_rel_cmd: assert property (
    cmd_wr && pwdata[3:0] == 4'h2 |-> ##[1:8] tx_valid && tx_frame == 3'h4)
    else $error("release command sent no DISC");
  chk_queue_start: assert property (
    cmd_wr && pwdata[3:0] == 4'h5 |-> ##[1:8] queue_valid && !queue_relink)
    else $error("queue start not linked");
  chk_queue_relink: assert property (
    cmd_wr && pwdata[3:0] == 4'h6 |-> ##[1:8] queue_valid && queue_relink)
    else $error("queue relink not linked");
  chk_bad_addr: assert property (
    psel && penable && paddr > 12'h01c |-> pready && pslverr)
    else $error("unmapped access not refused");
endmodule

bind lsc_link_ctrl lsc_link_ctrl_monitor #(.LW(LW)) mon (.*);

// >>> bench/lsc_peer_model.sv
// Remote station model: logs sent frames, sends frames on request and,
// in auto mode, answers SABME or DISC with UA.
// Assumes requests come from the bench right after a rising edge.
`timescale 1ns/1ns
`include "lsc_defs.svh"

module lsc_peer_model (
  // Clock and answer mode.
  input wire logic mclk,
  input wire logic auto_ua,
  // Frames from the block.
  input wire logic tx_valid,
  input wire logic [2:0] tx_frame,
  input wire logic [1:0] tx_link,
  // Frames to the block.
  output logic rx_valid,
  output logic [2:0] rx_frame,
  output logic rx_final,
  output logic [1:0] rx_link
);
  logic [6:0] req = 7'h00;
  logic [1:0] ans_lk = 2'h0;
  logic [1:0] wait_c = 2'h0;
  logic [2:0] last_fr = 3'h0;
  int n_tx = 0;

  initial begin
    {rx_valid, rx_final, rx_link, rx_frame} = 7'h00;
  end

  task automatic send(input logic [2:0] f, input logic fin,
                      input logic [1:0] lk);
    req <= {1'b1, fin, lk, f};
  endtask

  //////////////////////////////////////////////////////////////////////////
  always @(posedge mclk) begin
    // Idle lines keep changing so a stale frame code is never mistaken.
    rx_valid <= 1'b0;
    {rx_final, rx_link, rx_frame} <= ~{rx_final, rx_link, rx_frame};
    if (tx_valid) begin
      last_fr <= tx_frame;
      n_tx <= n_tx + 1;
    end
    if (auto_ua && tx_valid && tx_frame inside {`LSC_FR_SABME, `LSC_FR_DISC}) begin
      wait_c <= 2'h3;
      ans_lk <= tx_link;
    end else if (wait_c != 2'h0) begin
      wait_c <= wait_c - 2'h1;
    end
    if (wait_c == 2'h1) begin
      {rx_valid, rx_final, rx_link, rx_frame} <= {2'h3, ans_lk, `LSC_FR_UA};
    end else if (req[6]) begin
      {rx_valid, rx_final, rx_link, rx_frame} <= req;
      req <= 7'h00;
    end
  end
endmodule

// >>> bench/lsc_link_ctrl_bench.sv
// Self-checking bench for the link state control block.
// Assumes the design, its package and the peer model compile first.
`timescale 1ns/1ns
`include "lsc_defs.svh"

module lsc_link_ctrl_bench;
  // A short T200 keeps the retry run brief.
  localparam int unsigned T200 = 200;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic auto_ua = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, queue_head, rd, q_head;
  logic pready, pslverr, rx_valid, rx_final, tx_valid, abort_valid, err;
  logic queue_valid, queue_relink, q_rl;
  logic [2:0] rx_frame, tx_frame;
  logic [1:0] rx_link, tx_link, abort_link, queue_link, q_lk;
  int n_fail = 0, n_checks = 0, n_ab = 0, n0;

  lsc_link_ctrl #(.T200_CYC(T200), .T203_CYC(5000)) uut (.*);
  lsc_peer_model peer (.*);

  always #20 mclk = ~mclk;

  always @(posedge mclk) begin
    if (queue_valid) begin
      {q_head, q_rl, q_lk} <= {queue_head, queue_relink, queue_link};
    end
    if (abort_valid && abort_link == 2'h1) begin
      n_ab <= n_ab + 1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
    @(posedge mclk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    {rd, err} = {prdata, pslverr};
    {psel, penable} <= 2'b00;
  endtask

  task automatic cmd(input logic [3:0] c, input logic [1:0] lk);
    rd = 32'h0;
    while (rd[7:0] !== `LSC_SEM_READY) xfer(1'b0, `LSC_OFF_SEM, 32'h0);
    xfer(1'b1, `LSC_OFF_CMD, {22'h0, lk, 4'h0, c});
    repeat (4) @(posedge mclk);
  endtask

  task automatic st(input logic [3:0] e);
    xfer(1'b1, `LSC_OFF_SEL, 32'h1);
    xfer(1'b0, `LSC_OFF_STATUS, 32'h0);
    chk("link state", 32'(e), 32'(rd[3:0]));
  endtask

  task automatic ev(input logic [4:0] e);
    xfer(1'b0, `LSC_OFF_EVENT, 32'h0);
    chk("events", 32'({2'h1, e}), 32'({rd[9:8], rd[4:0]}));
  endtask

  task automatic rx(input logic [2:0] f, input logic fin, input logic [2:0] e);
    peer.send(f, fin, 2'h1);
    repeat (4) @(posedge mclk);
    chk("answer", 32'(e), 32'(peer.last_fr));
  endtask

  task automatic end_sim;
    if (n_fail == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge mclk);
    n_fail++;
    end_sim;
  end

  //////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge mclk);
    nrst <= 1'b1;
    xfer(1'b0, `LSC_OFF_SEM, 32'h0);
    chk("semaphore", 32'hff, 32'(rd[7:0]));
    xfer(1'b0, `LSC_OFF_CFG, 32'h0);
    chk("n200", 32'h3, 32'(rd[3:0]));
    xfer(1'b0, 12'h040, 32'h0);
    chk("unmapped", 32'h1, {rd[30:0], err});
    n0 = peer.n_tx;
    cmd(`LSC_CMD_ESTABLISH, 2'h1);
    st(`LSC_ST_AWAITING_ESTABLISHMENT_STATE);
    xfer(1'b0, `LSC_OFF_HIGHEST, 32'h0);
    chk("highest link", 32'h1, rd);
    repeat (3 * T200 + 50) @(posedge mclk);
    chk("sabme tries", n0 + 3, peer.n_tx);
    st(`LSC_ST_STATE_A);
    ev(5'h14);
    auto_ua <= 1'b1;
    cmd(`LSC_CMD_ESTABLISH, 2'h1);
    repeat (4) @(posedge mclk);
    auto_ua <= 1'b0;
    st(`LSC_ST_EST_NORMAL);
    chk("link variables", 32'h0, 32'(rd[29:4]));
    ev(5'h02);
    rx(`LSC_FR_SABME, 1'b0, `LSC_FR_UA);
    st(`LSC_ST_EST_NORMAL);
    chk("cleared by sabme", 32'h0, 32'(rd[29:4]));
    ev(5'h01);
    n0 = n_ab;
    rx(`LSC_FR_DISC, 1'b0, `LSC_FR_UA);
    chk("abort", n0 + 1, n_ab);
    st(`LSC_ST_STATE_A);
    ev(5'h04);
    cmd(`LSC_CMD_RELEASE, 2'h1);
    st(`LSC_ST_AWAITING_RELEASE_STATE);
    rx(`LSC_FR_SABME, 1'b0, `LSC_FR_DM);
    n0 = peer.n_tx;
    rx(`LSC_FR_OTHER, 1'b0, `LSC_FR_DM);
    chk("ignored frame", n0, peer.n_tx);
    rx(`LSC_FR_DM, 1'b1, `LSC_FR_DM);
    st(`LSC_ST_STATE_A);
    ev(5'h08);
    cmd(`LSC_CMD_ESTABLISH, 2'h1);
    rx(`LSC_FR_SABME, 1'b0, `LSC_FR_UA);
    rx(`LSC_FR_DISC, 1'b0, `LSC_FR_DM);
    st(`LSC_ST_AWAITING_ESTABLISHMENT_STATE);
    rx(`LSC_FR_DM, 1'b1, `LSC_FR_DM);
    st(`LSC_ST_STATE_A);
    ev(5'h04);
    xfer(1'b1, `LSC_OFF_QUEUE, 32'h1234_5670);
    cmd(`LSC_CMD_QUEUE_START, 2'h2);
    chk("queue head", 32'h1234_5670, q_head);
    chk("queue start", 32'h2, 32'({q_rl, q_lk}));
    cmd(`LSC_CMD_QUEUE_RELINK, 2'h2);
    chk("queue relink", 32'h6, 32'({q_rl, q_lk}));
    cmd(`LSC_CMD_TEI_REMOVE, 2'h1);
    st(`LSC_ST_TEI_UNASSIGNED);
    cmd(`LSC_CMD_DEACTIVATE, 2'h1);
    st(`LSC_ST_UNINIT);
    chk("active bit", 32'h0, 32'(rd[30]));
    xfer(1'b0, `LSC_OFF_SEM, 32'h0);
    chk("semaphore back", 32'hff, 32'(rd[7:0]));
    end_sim;
  end
endmodule
